// ---- core/sls_map.vh ----
`ifndef SLS_MAP_VH
`define SLS_MAP_VH
// ****************************************
// Register byte offsets
// ****************************************
`define SLS_OFF_CTRL      12'h000
`define SLS_OFF_C1_UPPER  12'h004
`define SLS_OFF_C1_LOWER  12'h008
`define SLS_OFF_C2_UPPER  12'h00c
`define SLS_OFF_C2_LOWER  12'h010
`define SLS_OFF_C2_SOURCE 12'h014
`define SLS_OFF_STATUS    12'h018
`define SLS_OFF_IRQ_STAT  12'h01c
`define SLS_OFF_IRQ_MASK  12'h020
`define SLS_OFF_PTR_VALUE 12'h024
// ****************************************
// Control fields
// ****************************************
`define SLS_CTRL_C1_LSB   0
`define SLS_CTRL_C2_LSB   4
`define SLS_MODE_W        3
// ****************************************
// Modes
// ****************************************
`define SLS_MODE_OFF      3'h0
`define SLS_MODE_LOW      3'h1
`define SLS_MODE_HIGH     3'h2
`define SLS_MODE_ABS_LOW  3'h3
`define SLS_MODE_ABS_HIGH 3'h4
// ****************************************
// Source selector codes
// ****************************************
`define SLS_SRC_SPEED_RPM   32'h40000101
`define SLS_SRC_SPEED_PCT   32'h40000102
`define SLS_SRC_FREQ        32'h40000103
`define SLS_SRC_CURRENT     32'h40000104
`define SLS_SRC_CURRENT_PCT 32'h40000105
`define SLS_SRC_TORQUE      32'h40000106
`define SLS_SRC_DC_VOLT     32'h40000107
`define SLS_SRC_PWR_INV     32'h40000116
`define SLS_SRC_PWR_MOTOR   32'h40000117
`define SLS_SRC_SREF_PRE    32'h40000303
`define SLS_SRC_SREF_POST   32'h40000305
`define SLS_SRC_SREF_APPL   32'h40000306
`define SLS_SRC_TREF_APPL   32'h4000030e
`define SLS_SRC_PROC_ACT    32'h40000403
`define SLS_SRC_PROC_LOOP   32'h40000405
// ****************************************
// Reset values
// ****************************************
`define SLS_RST_ZERO32    32'h00000000
`define SLS_RST_SOURCE    32'h40000101
`endif

// ---- core/sls_channel.v ----
`timescale 1ns/10ps
`include "sls_map.vh"
// One hysteresis comparator channel
module sls_channel #(
  parameter W = 32
) (
  input  wire                   mclk,        // Clock
  input  wire                   rst,         // Async reset, high
  input  wire [`SLS_MODE_W-1:0] mode,        // Supervision mode
  input  wire signed [W-1:0]    value,       // Monitored value
  input  wire signed [W-1:0]    upper,       // Upper limit
  input  wire signed [W-1:0]    lower,       // Lower limit
  output reg                    flag_q       // Supervision status bit
);
  reg  signed [W:0] val_x;
  reg               flag_d;
  wire signed [W:0] up_x = {upper[W-1], upper};
  wire signed [W:0] lo_x = {lower[W-1], lower};

  always @* begin
    val_x  = {value[W-1], value};
    if ((mode == `SLS_MODE_ABS_LOW || mode == `SLS_MODE_ABS_HIGH) && value[W-1]) begin
      val_x = -val_x;
    end
    flag_d = flag_q;
    case (mode)
      `SLS_MODE_LOW, `SLS_MODE_ABS_LOW: begin
        if (val_x < lo_x)
          flag_d = 1'b1;
        else if (val_x > up_x)
          flag_d = 1'b0;
      end
      `SLS_MODE_HIGH, `SLS_MODE_ABS_HIGH: begin
        if (val_x > up_x)
          flag_d = 1'b1;
        else if (val_x < lo_x)
          flag_d = 1'b0;
      end
      default: flag_d = 1'b0;
    endcase
  end

  always @(posedge mclk or posedge rst) begin
    if (rst)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end
endmodule

// ---- core/sls_top.v ----
// Summary of operation
// - Channel 2 selects its monitored drive signal
// - Each source has a fixed selector code
// - Channel 1 signed upper limit, hundredths scale
// - Channel 1 signed lower limit, hundredths scale
// - Mode 0 disables supervision
// - Low: set below lower, clear above upper
// - High: set above upper, clear below lower
// - Abs low: magnitude below lower sets
// - Abs high: magnitude above upper sets
// - Channel 1 same modes, status bit 0
// - Channel 2 signed limits, hundredths scale
`timescale 1ns/10ps
`include "sls_map.vh"
module sls_top #(
  parameter W = 32
) (
  input  wire              mclk,               // 200 MHz clock
  input  wire              rst,                // Async reset, high
  input  wire              psel,               // APB select
  input  wire              penable,            // APB enable
  input  wire              pwrite,             // APB write
  input  wire [11:0]       paddr,              // APB byte address
  input  wire [31:0]       pwdata,             // APB write data
  output reg  [31:0]       prdata,             // APB read data
  output reg               pready,             // APB ready
  output reg               pslverr,            // APB error
  input  wire [W-1:0]      chan1_value,        // Channel 1 monitored value
  input  wire [W-1:0]      motor_speed_rpm,    // Source signals, hundredths
  input  wire [W-1:0]      motor_speed_pct,    // Source
  input  wire [W-1:0]      output_freq,        // Source
  input  wire [W-1:0]      motor_current,      // Source
  input  wire [W-1:0]      motor_current_pct,  // Source
  input  wire [W-1:0]      motor_torque,       // Source
  input  wire [W-1:0]      dc_link_voltage,    // Source
  input  wire [W-1:0]      inverter_power,     // Source
  input  wire [W-1:0]      motor_power,        // Source
  input  wire [W-1:0]      speed_ref_before_ramp, // Source
  input  wire [W-1:0]      speed_ref_after_ramp,  // Source
  input  wire [W-1:0]      speed_ref_applied,  // Source
  input  wire [W-1:0]      torque_ref_applied, // Source
  input  wire [W-1:0]      process_actual,     // Source
  input  wire [W-1:0]      process_loop_output, // Source
  output reg  [1:0]        superv_status,      // Supervision status word
  output reg               irq                 // Level interrupt
);
  // ****************************************
  // Configuration registers
  // ****************************************
  reg  [`SLS_MODE_W-1:0] chan1_mode_select;
  reg  [`SLS_MODE_W-1:0] chan2_mode_select;
  reg  [W-1:0]           chan1_upper_limit;
  reg  [W-1:0]           chan1_lower_limit;
  reg  [W-1:0]           chan2_upper_limit;
  reg  [W-1:0]           chan2_lower_limit;
  reg  [31:0]            chan2_source_select;
  reg  [W-1:0]           pointer_value_q;
  reg  [1:0]             irq_stat_q;
  reg  [1:0]             irq_mask_q;
  reg  [W-1:0]           chan2_value_q;
  reg  [W-1:0]           chan2_value_d;
  reg  [1:0]             flag_prev_q;
  reg  [31:0]            rdata_d;
  reg                    err_d;
  wire                   chan1_flag;
  wire                   chan2_flag;
  wire [1:0]             flags;
  wire                   wr_en;
  wire                   access;

  assign access = psel & penable & pready;
  assign wr_en  = access & pwrite;
  assign flags  = {chan2_flag, chan1_flag};

  // ****************************************
  // APB slave: one wait state per access
  // ****************************************
  always @(posedge mclk or posedge rst) begin
    if (rst)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  always @* begin
    rdata_d = `SLS_RST_ZERO32;
    err_d   = 1'b0;
    case (paddr)
      `SLS_OFF_CTRL: begin
        rdata_d[`SLS_CTRL_C1_LSB +: `SLS_MODE_W] = chan1_mode_select;
        rdata_d[`SLS_CTRL_C2_LSB +: `SLS_MODE_W] = chan2_mode_select;
      end
      `SLS_OFF_C1_UPPER:  rdata_d = chan1_upper_limit;
      `SLS_OFF_C1_LOWER:  rdata_d = chan1_lower_limit;
      `SLS_OFF_C2_UPPER:  rdata_d = chan2_upper_limit;
      `SLS_OFF_C2_LOWER:  rdata_d = chan2_lower_limit;
      `SLS_OFF_C2_SOURCE: rdata_d = chan2_source_select;
      `SLS_OFF_STATUS:    rdata_d[1:0] = superv_status;
      `SLS_OFF_IRQ_STAT:  rdata_d[1:0] = irq_stat_q;
      `SLS_OFF_IRQ_MASK:  rdata_d[1:0] = irq_mask_q;
      `SLS_OFF_PTR_VALUE: rdata_d = pointer_value_q;
      default:            err_d = 1'b1;
    endcase
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata  <= `SLS_RST_ZERO32;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      prdata  <= pwrite ? `SLS_RST_ZERO32 : rdata_d;
      pslverr <= err_d;
    end else begin
      prdata  <= `SLS_RST_ZERO32;
      pslverr <= 1'b0;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      chan1_mode_select   <= `SLS_MODE_OFF;
      chan2_mode_select   <= `SLS_MODE_OFF;
      chan1_upper_limit   <= `SLS_RST_ZERO32;
      chan1_lower_limit   <= `SLS_RST_ZERO32;
      chan2_upper_limit   <= `SLS_RST_ZERO32;
      chan2_lower_limit   <= `SLS_RST_ZERO32;
      chan2_source_select <= `SLS_RST_SOURCE;
      pointer_value_q     <= `SLS_RST_ZERO32;
      irq_mask_q          <= 2'h0;
    end else if (wr_en) begin
      case (paddr)
        `SLS_OFF_CTRL: begin
          chan1_mode_select <= pwdata[`SLS_CTRL_C1_LSB +: `SLS_MODE_W];
          chan2_mode_select <= pwdata[`SLS_CTRL_C2_LSB +: `SLS_MODE_W];
        end
        `SLS_OFF_C1_UPPER:  chan1_upper_limit   <= pwdata[W-1:0];
        `SLS_OFF_C1_LOWER:  chan1_lower_limit   <= pwdata[W-1:0];
        `SLS_OFF_C2_UPPER:  chan2_upper_limit   <= pwdata[W-1:0];
        `SLS_OFF_C2_LOWER:  chan2_lower_limit   <= pwdata[W-1:0];
        `SLS_OFF_C2_SOURCE: chan2_source_select <= pwdata;
        `SLS_OFF_IRQ_MASK:  irq_mask_q          <= pwdata[1:0];
        `SLS_OFF_PTR_VALUE: pointer_value_q     <= pwdata[W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Channel 2 source selection
  // ****************************************
  always @* begin
    case (chan2_source_select)
      `SLS_SRC_SPEED_RPM:   chan2_value_d = motor_speed_rpm;
      `SLS_SRC_SPEED_PCT:   chan2_value_d = motor_speed_pct;
      `SLS_SRC_FREQ:        chan2_value_d = output_freq;
      `SLS_SRC_CURRENT:     chan2_value_d = motor_current;
      `SLS_SRC_CURRENT_PCT: chan2_value_d = motor_current_pct;
      `SLS_SRC_TORQUE:      chan2_value_d = motor_torque;
      `SLS_SRC_DC_VOLT:     chan2_value_d = dc_link_voltage;
      `SLS_SRC_PWR_INV:     chan2_value_d = inverter_power;
      `SLS_SRC_PWR_MOTOR:   chan2_value_d = motor_power;
      `SLS_SRC_SREF_PRE:    chan2_value_d = speed_ref_before_ramp;
      `SLS_SRC_SREF_POST:   chan2_value_d = speed_ref_after_ramp;
      `SLS_SRC_SREF_APPL:   chan2_value_d = speed_ref_applied;
      `SLS_SRC_TREF_APPL:   chan2_value_d = torque_ref_applied;
      `SLS_SRC_PROC_ACT:    chan2_value_d = process_actual;
      `SLS_SRC_PROC_LOOP:   chan2_value_d = process_loop_output;
      default:              chan2_value_d = pointer_value_q;
    endcase
  end

  always @(posedge mclk or posedge rst) begin
    if (rst)
      chan2_value_q <= `SLS_RST_ZERO32;
    else
      chan2_value_q <= chan2_value_d;
  end

  // ****************************************
  // Comparator channels
  // ****************************************
  sls_channel #(
    .W (W)
  ) u_chan1 (
    .mclk   (mclk),
    .rst    (rst),
    .mode   (chan1_mode_select),
    .value  (chan1_value),
    .upper  (chan1_upper_limit),
    .lower  (chan1_lower_limit),
    .flag_q (chan1_flag)
  );

  sls_channel #(
    .W (W)
  ) u_chan2 (
    .mclk   (mclk),
    .rst    (rst),
    .mode   (chan2_mode_select),
    .value  (chan2_value_q),
    .upper  (chan2_upper_limit),
    .lower  (chan2_lower_limit),
    .flag_q (chan2_flag)
  );

  // ****************************************
  // Status word and interrupts
  // ****************************************
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      superv_status <= 2'h0;
      flag_prev_q   <= 2'h0;
      irq_stat_q    <= 2'h0;
      irq           <= 1'b0;
    end else begin
      superv_status <= flags;
      flag_prev_q   <= flags;
      // Rising status edges set sticky bits; set wins over clear
      irq_stat_q    <= (irq_stat_q & ~((wr_en && paddr == `SLS_OFF_IRQ_STAT) ? pwdata[1:0] : 2'h0))
                       | (flags & ~flag_prev_q);
      irq           <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule

// ---- bench/sls_checker.sv ----
`timescale 1ns/10ps
module sls_checker #(
  parameter W = 32
) (
  input wire logic         mclk,          // Clock
  input wire logic         rst,           // Async reset
  input wire logic         psel,          // APB select
  input wire logic         penable,       // APB enable
  input wire logic         pwrite,        // APB write
  input wire logic [11:0]  paddr,         // APB address
  input wire logic [31:0]  pwdata,        // APB write data
  input wire logic         pready,        // APB ready
  input wire logic         pslverr,       // APB error
  input wire logic [W-1:0] chan1_value,   // Channel 1 input
  input wire logic [1:0]   superv_status, // Status word
  input wire logic         irq            // Interrupt
);
  logic [2:0]          m1_q;
  logic [1:0]          msk_q;
  logic signed [31:0]  up_q, lo_q;
  logic signed [W-1:0] x;
  logic                set_c, clr_c;
  // ****************************************
  // Shadow of channel 1 setup and interrupt mask
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      m1_q <= 3'h0;
      msk_q <= 2'h0;
      up_q <= 32'h0;
      lo_q <= 32'h0;
    end else if (psel && penable && pready && pwrite) begin
      case (paddr)
        12'h000: m1_q <= pwdata[2:0];
        12'h004: up_q <= pwdata;
        12'h008: lo_q <= pwdata;
        12'h020: msk_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end
  always_comb begin
    x = ((m1_q == 3'h3 || m1_q == 3'h4) && $signed(chan1_value) < 0) ? -$signed(chan1_value) : $signed(chan1_value);
    set_c = (m1_q == 3'h1 || m1_q == 3'h3) ? x < lo_q : ((m1_q == 3'h2 || m1_q == 3'h4) && x > up_q);
    clr_c = (m1_q == 3'h1 || m1_q == 3'h3) ? x > up_q : ((m1_q == 3'h2 || m1_q == 3'h4) ? x < lo_q : 1'b1);
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rdy_wait; psel && penable && !pready |=> pready; endproperty
  property p_rdy_pulse; pready |=> !pready; endproperty
  property p_err; psel && penable && pready && paddr > 12'h024 |-> pslverr; endproperty
  property p_rst_clear; $fell(rst) |-> superv_status == 2'b00 && !irq; endproperty
  property p_c1_set; set_c [*3] |-> superv_status[0]; endproperty
  property p_c1_clr; clr_c [*3] |-> !superv_status[0]; endproperty
  property p_c1_hold; (!set_c && !clr_c) [*4] |-> $stable(superv_status[0]); endproperty
  property p_irq_on; $rose(superv_status[0]) && msk_q[0] |-> ##[1:3] irq; endproperty
  property p_irq_off; msk_q == 2'b00 |=> !irq; endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("no ready after access");
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("unmapped access not refused");
  a_rst_clear: assert property (p_rst_clear) else $error("status not clear after reset");
  a_c1_set: assert property (p_c1_set) else $error("channel 1 bit not set");
  a_c1_clr: assert property (p_c1_clr) else $error("channel 1 bit not clear");
  a_c1_hold: assert property (p_c1_hold) else $error("channel 1 bit moved between limits");
  a_irq_on: assert property (p_irq_on) else $error("interrupt missing");
  a_irq_off: assert property (p_irq_off) else $error("masked interrupt raised");
  c_set: cover property (set_c [*3]);
  c_err: cover property (pslverr);
  c_irq: cover property (irq);
endmodule

// ---- bench/sls_drive_model.sv ----
`timescale 1ns/10ps
module sls_drive_model (
  input  wire logic [3:0]  pick,      // Index of source carrying level
  input  wire logic [31:0] level,     // Value of the picked source
  output logic [31:0]      src [0:14] // All drive source signals
);
  // Unpicked sources carry the inverse so a wrong selection shows
  always_comb begin
    for (int i = 0; i < 15; i++) src[i] = (i == pick) ? level : ~level;
  end
endmodule

// ---- bench/signal_limit_supervision_tb.sv ----
`timescale 1ns/10ps
`include "sls_map.vh"
module signal_limit_supervision_tb;
  logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, chan1_value = 32'h0, level = 32'h0, rd, lv;
  logic [3:0]  pick = 4'h0;
  wire  [31:0] prdata, src [0:14];
  wire  [1:0]  superv_status;
  wire         pready, pslverr, irq;
  int          mismatches = 0, n_compared = 0, m, k, i;
  int          lo_seq [4] = '{500, 1500, 2500, 1500};
  int          hi_seq [4] = '{2500, 1500, 500, 1500};
  int          bv [4] = '{3276800, 3276801, -3276800, -3276801};
  logic [31:0] codes [16] = '{`SLS_SRC_SPEED_RPM, `SLS_SRC_SPEED_PCT, `SLS_SRC_FREQ, `SLS_SRC_CURRENT,
    `SLS_SRC_CURRENT_PCT, `SLS_SRC_TORQUE, `SLS_SRC_DC_VOLT, `SLS_SRC_PWR_INV, `SLS_SRC_PWR_MOTOR,
    `SLS_SRC_SREF_PRE, `SLS_SRC_SREF_POST, `SLS_SRC_SREF_APPL, `SLS_SRC_TREF_APPL, `SLS_SRC_PROC_ACT,
    `SLS_SRC_PROC_LOOP, 32'h40000200};
  sls_top #(.W(32)) dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan1_value(chan1_value), .motor_speed_rpm(src[0]), .motor_speed_pct(src[1]), .output_freq(src[2]),
    .motor_current(src[3]), .motor_current_pct(src[4]), .motor_torque(src[5]), .dc_link_voltage(src[6]),
    .inverter_power(src[7]), .motor_power(src[8]), .speed_ref_before_ramp(src[9]),
    .speed_ref_after_ramp(src[10]), .speed_ref_applied(src[11]), .torque_ref_applied(src[12]),
    .process_actual(src[13]), .process_loop_output(src[14]), .superv_status(superv_status), .irq(irq));
  sls_drive_model drv_u (.pick(pick), .level(level), .src(src));
  always #2.5 mclk = ~mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic st1(input logic [31:0] v, input logic e);
    chan1_value <= v;
    repeat (4) @(posedge mclk);
    chk({31'h0, superv_status[0]}, {31'h0, e});
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rchk(`SLS_OFF_CTRL, 32'h0);
    rchk(`SLS_OFF_C2_SOURCE, `SLS_RST_SOURCE);
    chk({30'h0, superv_status}, 32'h0);
    $display("test reset done");
    apb(1'b1, `SLS_OFF_C1_UPPER, 32'd2000);
    apb(1'b1, `SLS_OFF_C1_LOWER, 32'd1000);
    apb(1'b1, `SLS_OFF_IRQ_MASK, 32'h1);
    for (m = 1; m < 5; m++) begin
      apb(1'b1, `SLS_OFF_CTRL, m);
      for (k = 0; k < 4; k++) st1((m > 2) ? -((m % 2) ? lo_seq[k] : hi_seq[k]) : ((m % 2) ? lo_seq[k] : hi_seq[k]), k < 2);
    end
    $display("test modes done");
    apb(1'b1, `SLS_OFF_C1_UPPER, 32'sd3276800);
    apb(1'b1, `SLS_OFF_C1_LOWER, -32'sd3276800);
    rchk(`SLS_OFF_C1_LOWER, 32'hffce0000);
    apb(1'b1, `SLS_OFF_CTRL, 32'h2);
    for (k = 0; k < 4; k++) st1(bv[k], k == 1 || k == 2);
    $display("test limits done");
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `SLS_OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `SLS_OFF_IRQ_STAT, 32'h1);
    rchk(`SLS_OFF_IRQ_STAT, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test irq done");
    apb(1'b1, `SLS_OFF_CTRL, 32'h20);
    apb(1'b1, `SLS_OFF_C2_UPPER, 32'd1000);
    apb(1'b1, `SLS_OFF_C2_LOWER, -32'sd1000);
    for (i = 0; i < 16; i++) begin
      apb(1'b1, `SLS_OFF_C2_SOURCE, codes[i]);
      pick <= i[3:0];
      for (k = 0; k < 2; k++) begin
        lv = k ? -32'sd2500 : 32'sd2500;
        level <= lv;
        apb(1'b1, `SLS_OFF_PTR_VALUE, (i == 15) ? lv : ~lv);
        repeat (4) @(posedge mclk);
        chk({30'h0, superv_status}, k ? 32'h0 : 32'h2);
      end
    end
    apb(1'b1, `SLS_OFF_PTR_VALUE, 32'd2500);
    repeat (4) @(posedge mclk);
    rchk(`SLS_OFF_STATUS, 32'h2);
    apb(1'b1, `SLS_OFF_CTRL, 32'h0);
    repeat (4) @(posedge mclk);
    chk({30'h0, superv_status}, 32'h0);
    $display("test channel 2 done");
    test_done;
  end
endmodule
bind sls_top sls_checker #(.W(W)) chk_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .chan1_value(chan1_value), .superv_status(superv_status), .irq(irq));
